// ### boost_pkg.sv
package boost_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned NS_PER_US     = 1000;
  localparam int unsigned CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
  localparam int unsigned RANGE_DIV     = 8;
  localparam int unsigned CYC_PER_UNIT_SCALED = CYC_PER_US / RANGE_DIV;

  // ----------------------------------------------------------------------
  // widths and limits
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned TICK_W  = 24;
  localparam int unsigned DUTY_W  = 7;
  localparam int unsigned LOAD_W  = 16;
  localparam int unsigned TAB_N   = 16;
  localparam int unsigned N_PINS  = 4;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 7'h64;

  // ----------------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_LIM  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD    = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_FB_LIM    = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_FB_GAIN   = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_SW_TARGET = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_CUT_LOAD  = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_COMP_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_ERR_BASE  = 8'h80;
  localparam logic [1:0]        TAB_SEL_COMP   = 2'h1;
  localparam logic [1:0]        TAB_SEL_ERR    = 2'h2;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTRL_ERR_MODE  = 0;
  localparam int unsigned CTRL_FLIP      = 1;
  localparam int unsigned CTRL_SCALE     = 2;
  localparam int unsigned CTRL_SEL_LO    = 4;
  localparam int unsigned STAT_CUT       = 8;
  localparam int unsigned STAT_SW        = 9;
  localparam int unsigned TAB_IDX_SHIFT  = 6;
  localparam int unsigned ERR_IDX_SHIFT  = 4;
  localparam int unsigned P_SHIFT        = 6;
  localparam int unsigned I_SHIFT        = 8;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_CTRL      = 16'h0020;
  localparam logic [DUTY_W-1:0] RST_FLOOR     = 7'h00;
  localparam logic [DUTY_W-1:0] RST_CEILING   = 7'h64;
  localparam logic [DATA_W-1:0] RST_PERIOD_US = 16'h80e8;
  localparam logic [DATA_W-1:0] RST_LOAD_MAX  = 16'hffff;

endpackage : boost_pkg

// ### boost_pwm_core.sv
`timescale 1ns/1ps
module boost_pwm_core
  import boost_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // settings latched at each period boundary; a shorter period ends the running one
  input  wire logic [TICK_W-1:0] period_ticks_i,
  input  wire logic [DUTY_W-1:0] duty_i,
  // waveform
  output logic                   energise_o,
  output logic                   period_end_o
);

  logic [TICK_W-1:0] cnt_r;
  logic [TICK_W-1:0] cnt_nxt;
  logic [TICK_W-1:0] per_r;
  logic [TICK_W-1:0] per_nxt;
  logic [TICK_W-1:0] cmp_r;
  logic [TICK_W-1:0] cmp_nxt;
  logic              en_r;
  logic              en_nxt;
  logic              end_r;
  logic              end_nxt;
  logic [TICK_W+DUTY_W-1:0] prod;
  logic              wrap;

  // ----------------------------------------------------------------------
  // counter and compare
  // ----------------------------------------------------------------------
  // duty waits for a wrap so a mid-period write never chops the pulse;
  // a shorter period ends the running one early, else a slow setting
  // would hold off a faster one for a whole long period
  always_comb begin
    prod    = period_ticks_i * duty_i;
    wrap    = (per_r == '0) || (cnt_r >= per_r - 1'b1) ||
              (period_ticks_i != '0 && cnt_r >= period_ticks_i - 1'b1);
    cnt_nxt = cnt_r + 1'b1;
    per_nxt = per_r;
    cmp_nxt = cmp_r;
    end_nxt = 1'b0;
    if (wrap) begin
      cnt_nxt = '0;
      per_nxt = period_ticks_i;
      cmp_nxt = TICK_W'(prod / DUTY_FULL);
      end_nxt = 1'b1;
    end
    en_nxt  = (per_r != '0) && (cnt_r < cmp_r);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
      per_r <= '0;
      cmp_r <= '0;
      en_r  <= 1'b0;
      end_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      per_r <= per_nxt;
      cmp_r <= cmp_nxt;
      en_r  <= en_nxt;
      end_r <= end_nxt;
    end
  end

  assign energise_o   = en_r;
  assign period_end_o = end_r;

endmodule : boost_pwm_core

// ### boost_solenoid_pwm_control.sv
`timescale 1ns/1ps
// Overview of operation
// - duty never above duty_ceiling unless duty_floor is set above duty_ceiling or output_polarity_flip is on
// - duty never below duty_floor unless duty_floor is set above duty_ceiling or output_polarity_flip is on
// - period from pwm_period_us, repeating
// - only outputs five to eight carry duty
// - low output energises the solenoid
// - output_polarity_flip gives complementary on-time
// - feedback correction capped at fb_pos_limit
// - feedback correction floored at fb_neg_limit
// - P+I only when error_table_mode off
// - switch input selects alternate target load
// - load above cut threshold cuts fuel
// - target is sum of four tables
// - compensation table maps target to duty
// - load below target adds error-table duty
// - freq_range_scale option, off by default
module boost_solenoid_pwm_control
  import boost_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // engine values from table lookups on this clock
  input  wire logic [LOAD_W-1:0] target_a_i,
  input  wire logic [LOAD_W-1:0] target_b_i,
  input  wire logic [LOAD_W-1:0] target_c_i,
  input  wire logic [LOAD_W-1:0] target_d_i,
  input  wire logic [DUTY_W-1:0] base_duty_table_i,
  input  wire logic [LOAD_W-1:0] load_i,
  // boost switch pin
  input  wire logic              boost_switch_i,
  // outputs five to eight, low side, low means energised
  output logic      [N_PINS-1:0] output_pin_o,
  output logic                   fuel_cut_o
);

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] ctrl_nxt;
  logic [DUTY_W-1:0] duty_floor_r;
  logic [DUTY_W-1:0] duty_floor_nxt;
  logic [DUTY_W-1:0] duty_ceiling_r;
  logic [DUTY_W-1:0] duty_ceiling_nxt;
  logic [DATA_W-1:0] pwm_period_us_r;
  logic [DATA_W-1:0] pwm_period_us_nxt;
  logic [7:0]        fb_pos_limit_r;
  logic [7:0]        fb_pos_limit_nxt;
  logic [7:0]        fb_neg_limit_r;
  logic [7:0]        fb_neg_limit_nxt;
  logic [7:0]        fb_proportional_gain_r;
  logic [7:0]        fb_proportional_gain_nxt;
  logic [7:0]        fb_integral_gain_r;
  logic [7:0]        fb_integral_gain_nxt;
  logic [LOAD_W-1:0] switch_target_r;
  logic [LOAD_W-1:0] switch_target_nxt;
  logic [LOAD_W-1:0] cut_load_r;
  logic [LOAD_W-1:0] cut_load_nxt;
  logic [DUTY_W-1:0] comp_tab_r [TAB_N];
  logic [DUTY_W-1:0] comp_tab_nxt [TAB_N];
  logic [DUTY_W-1:0] err_tab_r [TAB_N];
  logic [DUTY_W-1:0] err_tab_nxt [TAB_N];
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  logic              error_table_mode;
  logic              output_polarity_flip;
  logic              freq_range_scale;
  logic [1:0]        solenoid_pin_select;
  logic [DUTY_W-1:0] wduty;
  logic [1:0]        tab_sel;
  logic [3:0]        tab_idx;

  assign error_table_mode     = ctrl_r[CTRL_ERR_MODE];
  assign output_polarity_flip = ctrl_r[CTRL_FLIP];
  assign freq_range_scale     = ctrl_r[CTRL_SCALE];
  assign solenoid_pin_select  = ctrl_r[CTRL_SEL_LO+1:CTRL_SEL_LO];
  assign tab_sel              = addr_i[7:6];
  assign tab_idx              = addr_i[5:2];

  // ----------------------------------------------------------------------
  // live state seen by status read
  // ----------------------------------------------------------------------
  logic [DUTY_W-1:0] duty_r;
  logic              cut_r;
  logic              sw_sync_r;

  // duty fields saturate at full scale so the clamp can never pass 100 %
  always_comb begin
    wduty                    = (wdata_i[7:0] > 8'(DUTY_FULL)) ?
                               DUTY_FULL : wdata_i[DUTY_W-1:0];
    ctrl_nxt                 = ctrl_r;
    duty_floor_nxt           = duty_floor_r;
    duty_ceiling_nxt         = duty_ceiling_r;
    pwm_period_us_nxt        = pwm_period_us_r;
    fb_pos_limit_nxt         = fb_pos_limit_r;
    fb_neg_limit_nxt         = fb_neg_limit_r;
    fb_proportional_gain_nxt = fb_proportional_gain_r;
    fb_integral_gain_nxt     = fb_integral_gain_r;
    switch_target_nxt        = switch_target_r;
    cut_load_nxt             = cut_load_r;
    comp_tab_nxt             = comp_tab_r;
    err_tab_nxt              = err_tab_r;
    if (wr_i) begin
      case (addr_i)
        ADDR_CTRL: begin
          ctrl_nxt = {10'h000, wdata_i[5:4], 1'b0, wdata_i[2:0]};
        end
        ADDR_DUTY_LIM: begin
          duty_floor_nxt   = wduty;
          duty_ceiling_nxt = (wdata_i[15:8] > 8'(DUTY_FULL)) ?
                             DUTY_FULL : wdata_i[8+DUTY_W-1:8];
        end
        ADDR_PERIOD:    pwm_period_us_nxt = wdata_i;
        ADDR_FB_LIM: begin
          fb_pos_limit_nxt = wdata_i[7:0];
          fb_neg_limit_nxt = wdata_i[15:8];
        end
        ADDR_FB_GAIN: begin
          fb_proportional_gain_nxt = wdata_i[7:0];
          fb_integral_gain_nxt     = wdata_i[15:8];
        end
        ADDR_SW_TARGET: switch_target_nxt = wdata_i;
        ADDR_CUT_LOAD:  cut_load_nxt      = wdata_i;
        default: begin
          if (tab_sel == TAB_SEL_COMP && addr_i[1:0] == 2'h0) begin
            comp_tab_nxt[tab_idx] = wduty;
          end else if (tab_sel == TAB_SEL_ERR && addr_i[1:0] == 2'h0) begin
            err_tab_nxt[tab_idx] = wduty;
          end
        end
      endcase
    end
    rdata_nxt = '0;
    if (rd_i) begin
      case (addr_i)
        ADDR_CTRL:      rdata_nxt = ctrl_r;
        ADDR_DUTY_LIM:  rdata_nxt = {1'b0, duty_ceiling_r,
                                     1'b0, duty_floor_r};
        ADDR_PERIOD:    rdata_nxt = pwm_period_us_r;
        ADDR_FB_LIM:    rdata_nxt = {fb_neg_limit_r, fb_pos_limit_r};
        ADDR_FB_GAIN:   rdata_nxt = {fb_integral_gain_r,
                                     fb_proportional_gain_r};
        ADDR_SW_TARGET: rdata_nxt = switch_target_r;
        ADDR_CUT_LOAD:  rdata_nxt = cut_load_r;
        ADDR_STATUS:    rdata_nxt = {6'h00, sw_sync_r, cut_r,
                                     1'b0, duty_r};
        default: begin
          if (tab_sel == TAB_SEL_COMP && addr_i[1:0] == 2'h0) begin
            rdata_nxt = {9'h000, comp_tab_r[tab_idx]};
          end else if (tab_sel == TAB_SEL_ERR && addr_i[1:0] == 2'h0) begin
            rdata_nxt = {9'h000, err_tab_r[tab_idx]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_r                 <= RST_CTRL;
      duty_floor_r           <= RST_FLOOR;
      duty_ceiling_r         <= RST_CEILING;
      pwm_period_us_r        <= RST_PERIOD_US;
      fb_pos_limit_r         <= '0;
      fb_neg_limit_r         <= '0;
      fb_proportional_gain_r <= '0;
      fb_integral_gain_r     <= '0;
      switch_target_r        <= '0;
      cut_load_r             <= RST_LOAD_MAX;
      rdata_r                <= '0;
      for (int i = 0; i < TAB_N; i++) begin
        comp_tab_r[i] <= '0;
        err_tab_r[i]  <= '0;
      end
    end else begin
      ctrl_r                 <= ctrl_nxt;
      duty_floor_r           <= duty_floor_nxt;
      duty_ceiling_r         <= duty_ceiling_nxt;
      pwm_period_us_r        <= pwm_period_us_nxt;
      fb_pos_limit_r         <= fb_pos_limit_nxt;
      fb_neg_limit_r         <= fb_neg_limit_nxt;
      fb_proportional_gain_r <= fb_proportional_gain_nxt;
      fb_integral_gain_r     <= fb_integral_gain_nxt;
      switch_target_r        <= switch_target_nxt;
      cut_load_r             <= cut_load_nxt;
      rdata_r                <= rdata_nxt;
      comp_tab_r             <= comp_tab_nxt;
      err_tab_r              <= err_tab_nxt;
    end
  end

  assign rdata_o = rdata_r;

  // ----------------------------------------------------------------------
  // switch synchroniser
  // ----------------------------------------------------------------------
  logic sw_meta_r;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sw_meta_r <= 1'b0;
      sw_sync_r <= 1'b0;
    end else begin
      sw_meta_r <= boost_switch_i;
      sw_sync_r <= sw_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // target, lookups and feedback
  // ----------------------------------------------------------------------
  logic [LOAD_W+1:0]        tgt_sum;
  logic [LOAD_W-1:0]        target;
  logic signed [LOAD_W:0]   err;
  logic [3:0]               comp_idx;
  logic [3:0]               err_idx;
  logic [DUTY_W-1:0]        comp_duty;
  logic [DUTY_W-1:0]        err_duty;
  logic signed [25:0]       p_term;
  logic signed [25:0]       i_step;
  logic signed [25:0]       i_sum;
  logic signed [25:0]       c_sum;
  logic signed [11:0]       integ_r;
  logic signed [11:0]       integ_nxt;
  logic signed [11:0]       corr;
  logic signed [11:0]       total;
  logic [DUTY_W-1:0]        clamped;
  logic [DUTY_W-1:0]        duty_nxt;
  logic                     cut_nxt;
  logic                     period_end;

  // keeps a signed term within [-neg, +pos]
  function automatic logic signed [11:0] limit_fb(
    input logic signed [25:0] v,
    input logic [7:0]         pos,
    input logic [7:0]         neg
  );
    if (v > $signed({18'h00000, pos})) begin
      limit_fb = $signed({4'h0, pos});
    end else if (v < -$signed({18'h00000, neg})) begin
      limit_fb = -$signed({4'h0, neg});
    end else begin
      limit_fb = v[11:0];
    end
  endfunction : limit_fb

  always_comb begin
    tgt_sum = {2'b00, target_a_i} + {2'b00, target_b_i}
            + {2'b00, target_c_i} + {2'b00, target_d_i};
    if (sw_sync_r) begin
      target = switch_target_r;
    end else if (tgt_sum[LOAD_W+1:LOAD_W] != 2'b00) begin
      target = RST_LOAD_MAX;
    end else begin
      target = tgt_sum[LOAD_W-1:0];
    end
    err = $signed({1'b0, target}) - $signed({1'b0, load_i});
    // coarse index; anything past the last bin uses the last entry
    comp_idx  = (target[LOAD_W-1:TAB_IDX_SHIFT+4] != '0) ? 4'hf :
                target[TAB_IDX_SHIFT+3:TAB_IDX_SHIFT];
    comp_duty = comp_tab_r[comp_idx];
    err_idx   = (err[LOAD_W-1:ERR_IDX_SHIFT+4] != '0) ? 4'hf :
                err[ERR_IDX_SHIFT+3:ERR_IDX_SHIFT];
    err_duty  = '0;
    if (error_table_mode && err > 0) begin
      err_duty = err_tab_r[err_idx];
    end
    p_term = (26'(err) * 26'($signed(fb_proportional_gain_r)))
             >>> P_SHIFT;
    i_step = (26'(err) * 26'($signed(fb_integral_gain_r))) >>> I_SHIFT;
    i_sum  = 26'(integ_r) + i_step;
    c_sum  = p_term + 26'(integ_r);
    // integrator shares the output limits to stop wind-up
    integ_nxt = integ_r;
    if (error_table_mode) begin
      integ_nxt = '0;
    end else if (period_end) begin
      integ_nxt = limit_fb(i_sum, fb_pos_limit_r, fb_neg_limit_r);
    end
    corr = '0;
    if (!error_table_mode) begin
      corr = limit_fb(c_sum, fb_pos_limit_r, fb_neg_limit_r);
    end
    total = $signed({5'h00, base_duty_table_i})
          + $signed({5'h00, comp_duty})
          + $signed({5'h00, err_duty}) + corr;
    clamped = total[DUTY_W-1:0];
    if (total < $signed({5'h00, duty_floor_r})) begin
      clamped = duty_floor_r;
    end
    // ceiling checked last, but against total: a floor set above it wins while total is at or below the ceiling
    if (total > $signed({5'h00, duty_ceiling_r})) begin
      clamped = duty_ceiling_r;
    end
    duty_nxt = output_polarity_flip ? DUTY_FULL - clamped : clamped;
    cut_nxt  = load_i > cut_load_r;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      integ_r <= '0;
      duty_r  <= '0;
      cut_r   <= 1'b0;
    end else begin
      integ_r <= integ_nxt;
      duty_r  <= duty_nxt;
      cut_r   <= cut_nxt;
    end
  end

  assign fuel_cut_o = cut_r;

  // ----------------------------------------------------------------------
  // waveform and pin drive
  // ----------------------------------------------------------------------
  logic [TICK_W-1:0] period_ticks;
  logic              energise;
  logic [N_PINS-1:0] pin_r;
  logic [N_PINS-1:0] pin_nxt;

  always_comb begin
    period_ticks = freq_range_scale ?
      TICK_W'(pwm_period_us_r * CYC_PER_UNIT_SCALED) :
      TICK_W'(pwm_period_us_r * CYC_PER_US);
  end

  boost_pwm_core u_core (
    .clk_i          (clk_i),
    .rstn_i         (rstn_i),
    .period_ticks_i (period_ticks),
    .duty_i         (duty_r),
    .energise_o     (energise),
    .period_end_o   (period_end)
  );

  // unselected outputs idle high so their loads stay de-energised
  for (genvar g = 0; g < N_PINS; g++) begin : g_pin
    always_comb begin
      pin_nxt[g] = !(energise && solenoid_pin_select == 2'(g));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pin_r <= '1;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign output_pin_o = pin_r;

endmodule : boost_solenoid_pwm_control

// ### boost_pwm_sva.sv
`timescale 1ns/1ps
module boost_pwm_checker
  import boost_pkg::*;
(
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rstn_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  // engine side
  input wire logic [LOAD_W-1:0] load_i,
  input wire logic [N_PINS-1:0] output_pin_o,
  input wire logic              fuel_cut_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // --------------------------------------------------------------------
  // register shadows; arm waits two falls so a period still
  // running on old settings is never judged
  // --------------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_r, per_r, cut_r;
  logic [6:0]        flo_r, cei_r;
  logic [23:0]       low_r, gap_r;
  logic [1:0]        arm_r;
  logic              pin, pin_q;
  logic [31:0]       ticks;
  assign pin = output_pin_o[ctrl_r[5:4]];
  assign ticks = per_r * (ctrl_r[CTRL_SCALE] ? 32'h19 : 32'hc8);
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_r <= RST_CTRL;
      per_r  <= RST_PERIOD_US;
      cut_r  <= RST_LOAD_MAX;
      flo_r  <= RST_FLOOR;
      cei_r  <= RST_CEILING;
      arm_r  <= 2'h0;
    end else begin
      if (wr_i && addr_i == ADDR_CTRL) ctrl_r <= wdata_i;
      if (wr_i && addr_i == ADDR_PERIOD) per_r <= wdata_i;
      if (wr_i && addr_i == ADDR_CUT_LOAD) cut_r <= wdata_i;
      if (wr_i && addr_i == ADDR_DUTY_LIM) begin
        flo_r <= (wdata_i[7:0] > 8'h64) ? 7'h64 : wdata_i[6:0];
        cei_r <= (wdata_i[15:8] > 8'h64) ? 7'h64 : wdata_i[14:8];
      end
      if (wr_i) arm_r <= 2'h0;
      else if (pin_q && !pin && arm_r != 2'h2) arm_r <= arm_r + 2'h1;
    end
    pin_q <= pin;
    low_r <= pin ? 24'h0 : low_r + 24'h1;
    gap_r <= (pin_q && !pin) ? 24'h1 : gap_r + 24'h1;
  end
  sequence s_rise;
    !pin ##1 pin ##0 arm_r == 2'h2 && !ctrl_r[CTRL_FLIP];
  endsequence
  sequence s_fall;
    pin ##1 !pin ##0 arm_r == 2'h2 && ticks != 32'h0;
  endsequence
  ceiling_run_a: assert property (
    s_rise |-> low_r * 32'h64 <= ticks * cei_r)
    else $error("on-time above ceiling");
  floor_run_a: assert property (
    s_rise |-> low_r * 32'h64 + 32'h64 > ticks * flo_r)
    else $error("on-time below floor");
  period_gap_a: assert property (
    s_fall |-> (32'(gap_r) % ticks) == 32'h0)
    else $error("period start off the period grid");
  reset_idle_a: assert property (
    $rose(rstn_i) |-> output_pin_o == 4'hf && !fuel_cut_o)
    else $error("outputs not idle after reset");
  single_low_a: assert property ($onehot0(~output_pin_o))
    else $error("more than one output low");
  unselected_high_a: assert property (
    $stable(ctrl_r) |->
      (output_pin_o | (4'h1 << ctrl_r[5:4])) == 4'hf)
    else $error("unselected output low");
  fuel_cut_a: assert property (
    $past(rstn_i) |-> fuel_cut_o == ($past(load_i) > $past(cut_r)))
    else $error("fuel cut wrong for load");
  ctrl_fields_a: assert property (
    rd_i && addr_i == ADDR_CTRL |=> (rdata_o & 16'hffc8) == 16'h0)
    else $error("reserved control bits read nonzero");
endmodule : boost_pwm_checker

bind boost_solenoid_pwm_control boost_pwm_checker boost_pwm_checker_inst (
  .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .load_i(load_i),
  .output_pin_o(output_pin_o), .fuel_cut_o(fuel_cut_o));

// ### wastegate_solenoid.sv
`timescale 1ns/1ps
module wastegate_solenoid (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  // low-side drive from the block
  input  wire logic   drive_n_i,
  output logic        energised_o,
  // last whole period: energised cycles, length, end pulse
  output logic [23:0] on_o,
  output logic [23:0] per_o,
  output logic        fall_o
);
  logic        prev_r;
  logic [23:0] lo_r, gap_r;
  assign energised_o = ~drive_n_i;
  always_ff @(posedge clk_i) begin
    prev_r <= rstn_i ? drive_n_i : 1'b1;
    fall_o <= rstn_i & prev_r & ~drive_n_i;
    if (prev_r && !drive_n_i) begin
      on_o  <= lo_r;
      per_o <= gap_r;
      lo_r  <= 24'h1;
      gap_r <= 24'h1;
    end else begin
      lo_r  <= lo_r + {23'h0, ~drive_n_i};
      gap_r <= gap_r + 24'h1;
    end
  end
endmodule : wastegate_solenoid

// ### tb_boost_solenoid_pwm_control.sv
`timescale 1ns/1ps
module tb_boost_solenoid_pwm_control
  import boost_pkg::*;
;
  logic              clk_i = 1'b0;
  logic              rstn_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic              wr_i = 1'b0;
  logic              rd_i = 1'b0;
  logic [LOAD_W-1:0] tgt_a = '0, tgt_b = '0, tgt_c = '0, tgt_d = '0;
  logic [LOAD_W-1:0] load = '0;
  logic [DUTY_W-1:0] base = '0;
  logic              sw = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic [N_PINS-1:0] output_pin_o;
  logic              fuel_cut_o, fall_p;
  logic [23:0]       on_cyc, per_cyc;
  int                n_fail = 0, num_checks = 0, cyc = 0;
  always #2.5 clk_i = ~clk_i;
  boost_solenoid_pwm_control boost_solenoid_pwm_control_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .target_a_i(tgt_a),
    .target_b_i(tgt_b), .target_c_i(tgt_c), .target_d_i(tgt_d),
    .base_duty_table_i(base), .load_i(load), .boost_switch_i(sw),
    .output_pin_o(output_pin_o), .fuel_cut_o(fuel_cut_o));
  wastegate_solenoid wastegate_solenoid_inst (
    .clk_i(clk_i), .rstn_i(rstn_i), .drive_n_i(output_pin_o[0]),
    .energised_o(), .on_o(on_cyc), .per_o(per_cyc), .fall_o(fall_p));
  // --------------------------------------------------------------------
  // bus and compare helpers
  // --------------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 chk(24'(rdata_o), 24'(e));
  endtask : rd
  // settings latch at the wrap, so one period may still be old
  task automatic meas(input logic [23:0] on, input logic [23:0] per);
    repeat (3) @(posedge fall_p);
    #1 chk(on_cyc, on);
    chk(per_cyc, per);
  endtask : meas
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_reset;
    chk(24'(output_pin_o), 24'hf);
    rd(ADDR_CTRL, 16'h0020);
    rd(ADDR_DUTY_LIM, 16'h6400);
    rd(ADDR_PERIOD, 16'h80e8);
    rd(8'h20, 16'h0);
    wr(ADDR_DUTY_LIM, 16'h7f00);
    rd(ADDR_DUTY_LIM, 16'h6400);
  endtask : t_reset
  task automatic t_wave;
    wr(ADDR_PERIOD, 16'h0001);
    wr(ADDR_CTRL, 16'h0000);
    base <= 7'h32;
    meas(24'h64, 24'hc8);
  endtask : t_wave
  task automatic t_clamp;
    wr(ADDR_DUTY_LIM, 16'h5014);
    base <= 7'h5f;
    meas(24'ha0, 24'hc8);
    base <= 7'h05;
    meas(24'h28, 24'hc8);
    wr(ADDR_DUTY_LIM, 16'h6400);
  endtask : t_clamp
  task automatic t_comp;
    tgt_a <= 16'h30;
    tgt_b <= 16'h30;
    tgt_c <= 16'h30;
    tgt_d <= 16'h30;
    base  <= 7'h0a;
    wr(8'h4c, 16'h001e);
    meas(24'h50, 24'hc8);
    sw <= 1'b1;
    meas(24'h14, 24'hc8);
    sw <= 1'b0;
  endtask : t_comp
  task automatic t_err;
    wr(8'h88, 16'h000f);
    wr(ADDR_FB_GAIN, 16'h0040);
    load <= 16'ha0;
    wr(ADDR_CTRL, 16'h0001);
    meas(24'h6e, 24'hc8);
    wr(ADDR_CTRL, 16'h0002);
    meas(24'h78, 24'hc8);
  endtask : t_err
  task automatic t_pi;
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_FB_LIM, 16'h0705);
    load <= 16'h0;
    meas(24'h5a, 24'hc8);
    load <= 16'h3e8;
    meas(24'h42, 24'hc8);
    wr(ADDR_FB_LIM, 16'h0000);
  endtask : t_pi
  task automatic t_fuel;
    wr(ADDR_CUT_LOAD, 16'h03e8);
    @(posedge clk_i);
    #1 chk(24'(fuel_cut_o), 24'h0);
    load <= 16'h3e9;
    @(posedge clk_i);
    #1 chk(24'(fuel_cut_o), 24'h1);
    rd(ADDR_STATUS, 16'h0128);
    load <= 16'h0;
  endtask : t_fuel
  task automatic t_scale;
    wr(ADDR_CTRL, 16'h0004);
    wr(ADDR_PERIOD, 16'h0008);
    meas(24'h50, 24'hc8);
  endtask : t_scale
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_wave();
    t_clamp();
    t_comp();
    t_err();
    t_pi();
    t_fuel();
    t_scale();
    print_verdict();
  end
endmodule : tb_boost_solenoid_pwm_control
